// [hw/exec_pkg.sv]
// Shared constants and carriers for the load, jump and mirror execution block
package exec_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses, 8-bit bus address)
  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_FLAG = 8'h08;
  localparam logic [7:0] ADR_CFG = 8'h0C;
  localparam logic [7:0] ADR_HIGH = 8'h10;
  localparam logic [7:0] ADR_MTX = 8'h14;
  localparam int RF_SEL_BIT = 7;

  //////////////////////////////////////////////////////////////////////////////
  // Operation codes
  localparam logic [3:0] OP_JUMP = 4'h0;
  localparam logic [3:0] OP_LONG = 4'h1;
  localparam logic [3:0] OP_IDX = 4'h2;
  localparam logic [3:0] OP_ROFF = 4'h3;
  localparam logic [3:0] OP_BYTE = 4'h4;
  localparam logic [3:0] OP_HALF = 4'h5;
  localparam logic [3:0] OP_PHRASE = 4'h6;
  localparam logic [3:0] OP_MIRROR = 4'h7;
  localparam logic [3:0] OP_MMUL = 4'h8;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CC_ZCLR = 0;
  localparam int CC_ZSET = 1;
  localparam int CC_SCLR = 2;
  localparam int CC_SSET = 3;
  localparam int CC_SEL = 4;
  localparam int ST_BUSY = 0;
  localparam int ST_TAKEN = 1;
  localparam int ST_ALIGN = 2;
  localparam int ST_ILLEGAL = 3;
  localparam int FL_Z = 0;
  localparam int FL_N = 1;
  localparam int FL_C = 2;
  localparam int CFG_GFX = 0;
  localparam int CFG_DSP = 1;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values, address window, timing counts
  localparam logic [2:0] FLAG_RST = 3'h0;
  localparam logic [1:0] CFG_RST = 2'h3;
  localparam logic [31:0] MTX_RST = 32'h0001_0000;
  localparam logic [31:0] INT_BASE = 32'h0001_0000;
  localparam logic [31:0] INT_MASK = 32'hFFFF_F000;
  localparam logic [4:0] IDX_A_REG = 5'h0E;
  localparam logic [4:0] IDX_B_REG = 5'h0F;
  localparam logic [1:0] IDX_EXTRA = 2'h2;
  localparam logic [1:0] MTX_LAST = 2'h3;

  //////////////////////////////////////////////////////////////////////////////
  // Carriers
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] SZ_PHRASE = 2'h3;

  typedef struct packed {
    logic [3:0] op;
    logic base_b;
    logic [4:0] imm;
    logic [4:0] rs;
    logic [4:0] rd;
  } cmd_t;

  typedef struct packed {
    logic req;
    logic [1:0] size;
    logic [31:0] addr;
  } ext_req_t;

endpackage

// [hw/jump_cond.sv]
// Condition-code evaluator for conditional jumps
module jump_cond
#(
  parameter int W = 5
)
(
  input wire logic [W-1:0] cc_i,
  input wire logic zero_i,
  input wire logic neg_i,
  input wire logic carry_i,
  output logic take_o
);
  import exec_pkg::*;

  logic sel_flag;

  // Selector picks negative when set, carry when clear
  assign sel_flag = cc_i[CC_SEL] ? neg_i : carry_i; // see RL5
  // All requested conditions must hold together
  assign take_o = (!cc_i[CC_ZCLR] || !zero_i) && // see RL1 see RL6
                  (!cc_i[CC_ZSET] || zero_i) && // see RL2
                  (!cc_i[CC_SCLR] || !sel_flag) && // see RL3
                  (!cc_i[CC_SSET] || sel_flag); // see RL4
endmodule // jump_cond

// [hw/bit_mirror.sv]
// Bit reversal of one word
module bit_mirror
#(
  parameter int W = 32
)
(
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  for (genvar i = 0; i < W; i++)
  begin : g_rev
    assign q_o[i] = d_i[W-1-i]; // see RL18
  end
endmodule // bit_mirror

// [hw/exec_unit.sv]
// Execution unit: conditional jump, loads, mirror and matrix multiply
// Behaviour
// RL1 - Bit 0: jump needs zero clear
// RL2 - Bit 1: jump needs zero set
// RL3 - Bit 2: selected flag must be clear
// RL4 - Bit 3: selected flag must be set
// RL5 - Selector: negative if one, else carry
// RL6 - Several condition bits are ANDed
// RL7 - Flags sampled cycle 1, left unchanged
// RL8 - Long load: aligned source address, 32 bits
// RL9 - Internal long load writes cycle 3
// RL10 - Indexed address: base plus imm longwords
// RL11 - Indexed loads write in cycle 5
// RL12 - Register-offset: base plus source, aligned
// RL13 - External byte load zero-extends
// RL14 - External half load aligned, zero-extends
// RL15 - Internal narrow/phrase loads read 32 bits
// RL16 - Phrase: graphics only, aligned, high latched
// RL17 - Every load updates the high word latch
// RL18 - Mirror reverses bits, signal core only
// RL19 - Mirror sets Z N, writes cycle 3
// RL20 - Matrix multiply accumulates, flags from final
// RL21 - External loads stall until bus answers
module exec_unit
(
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic INT_RD_O,
  output logic [31:0] INT_ADDR_O,
  input wire logic [31:0] INT_RDATA_I,
  output exec_pkg::ext_req_t EXT_REQ_O,
  input wire logic EXT_ACK_I,
  input wire logic [63:0] EXT_RDATA_I,
  output logic BUSY_O,
  output logic JUMP_TAKEN_O
);
  import exec_pkg::*;
  typedef enum logic [3:0] {S_IDLE, S_C1, S_ADR, S_ISSUE, S_WB_INT, S_WAIT_EXT, S_MIR, S_MMUL_RD,
                            S_MMUL_ACC, S_WB} state_t;
  state_t st_ff;
  cmd_t cmd_ff;
  logic ack_ff, taken_ff, align_ff, illegal_ff;
  logic [2:0] flag_ff;
  logic [1:0] cfg_ff, cnt_ff, k_ff;
  logic [31:0] rf_ff [32];
  logic [31:0] addr_ff, high_ff, mtx_ff, res_ff, dat_ff, acc_ff, wb_data, rd_mux, c1_addr, wmask, mir_q;
  logic [32:0] acc_sum;
  logic [31:0] prod;
  logic bus_wr, cmd_go, rf_we, is_load, is_int, misalign, illegal_op, take;
  logic [4:0] mtx_reg;
  //////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after request, write commits on ack edge
  assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign bus_wr = WB_CYC_I && WB_STB_I && WB_WE_I && ack_ff;
  assign cmd_go = bus_wr && (WB_ADR_I == ADR_CMD) && (st_ff == S_IDLE);
  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = dat_ff;
  assign BUSY_O = (st_ff != S_IDLE);
  assign JUMP_TAKEN_O = taken_ff;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (WB_ADR_I[RF_SEL_BIT])
      rd_mux = rf_ff[WB_ADR_I[6:2]];
    else
      unique case (WB_ADR_I)
        ADR_CMD: rd_mux = {12'h000, cmd_ff};
        ADR_STAT: rd_mux = {28'h0000000, illegal_ff, align_ff, taken_ff, BUSY_O};
        ADR_FLAG: rd_mux = {29'h00000000, flag_ff};
        ADR_CFG: rd_mux = {30'h00000000, cfg_ff};
        ADR_HIGH: rd_mux = high_ff;
        ADR_MTX: rd_mux = mtx_ff;
        default: rd_mux = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= WB_CYC_I && WB_STB_I && !ack_ff;
      if (WB_CYC_I && WB_STB_I && !ack_ff)
        dat_ff <= rd_mux;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      cmd_ff <= '0;
      cfg_ff <= CFG_RST;
      mtx_ff <= MTX_RST;
    end
    else if (bus_wr)
    begin
      if (cmd_go)
        cmd_ff <= cmd_t'(20'((WB_DAT_I & wmask) | ({12'h000, cmd_ff} & ~wmask)));
      if (WB_ADR_I == ADR_CFG && WB_SEL_I[0])
        cfg_ff <= WB_DAT_I[1:0];
      if (WB_ADR_I == ADR_MTX)
        mtx_ff <= (WB_DAT_I & wmask) | (mtx_ff & ~wmask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Cycle-1 decode: operand address and checks
  assign is_load = (cmd_ff.op >= OP_LONG) && (cmd_ff.op <= OP_PHRASE);
  always_comb
  begin
    c1_addr = rf_ff[cmd_ff.rs]; // see RL8
    if (cmd_ff.op == OP_IDX) // see RL10
      c1_addr = rf_ff[cmd_ff.base_b ? IDX_B_REG : IDX_A_REG] + {24'h000000, (cmd_ff.imm == 5'h00), cmd_ff.imm, 2'h0};
    else if (cmd_ff.op == OP_ROFF) // see RL12
      c1_addr = rf_ff[cmd_ff.base_b ? IDX_B_REG : IDX_A_REG] + rf_ff[cmd_ff.rs];
  end
  assign misalign = ((cmd_ff.op == OP_LONG || cmd_ff.op == OP_IDX || cmd_ff.op == OP_ROFF) && c1_addr[1:0] != 2'h0) ||
                    (cmd_ff.op == OP_HALF && c1_addr[0]) || // see RL14
                    (cmd_ff.op == OP_PHRASE && c1_addr[2:0] != 3'h0); // see RL16
  assign illegal_op = (cmd_ff.op == OP_PHRASE && !cfg_ff[CFG_GFX]) || (cmd_ff.op == OP_MIRROR && !cfg_ff[CFG_DSP]) ||
                      (cmd_ff.op > OP_MMUL);
  assign is_int = ((addr_ff & INT_MASK) == INT_BASE);
  jump_cond #(.W(5)) u_cond (
    .cc_i(cmd_ff.imm),
    .zero_i(flag_ff[FL_Z]),
    .neg_i(flag_ff[FL_N]),
    .carry_i(flag_ff[FL_C]),
    .take_o(take)
  );
  bit_mirror #(.W(32)) u_mir (
    .d_i(res_ff),
    .q_o(mir_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      st_ff <= S_IDLE;
      cnt_ff <= 2'h0;
      k_ff <= 2'h0;
      addr_ff <= 32'h0000_0000;
    end
    else
      unique case (st_ff)
        S_IDLE: if (cmd_go) st_ff <= S_C1;
        S_C1:
        begin
          addr_ff <= (cmd_ff.op == OP_MMUL) ? mtx_ff : c1_addr;
          cnt_ff <= 2'h1;
          k_ff <= 2'h0;
          if (illegal_op || (is_load && misalign) || cmd_ff.op == OP_JUMP)
            st_ff <= S_IDLE; // see RL7
          else if (cmd_ff.op == OP_IDX || cmd_ff.op == OP_ROFF)
            st_ff <= S_ADR; // see RL11
          else if (is_load)
            st_ff <= S_ISSUE; // see RL9
          else if (cmd_ff.op == OP_MIRROR)
            st_ff <= S_MIR;
          else
            st_ff <= S_MMUL_RD; // see RL20
        end
        S_ADR:
        begin
          cnt_ff <= cnt_ff + 2'h1;
          if (cnt_ff == IDX_EXTRA)
            st_ff <= S_ISSUE;
        end
        S_ISSUE: st_ff <= is_int ? S_WB_INT : S_WAIT_EXT;
        S_WB_INT: st_ff <= S_IDLE;
        S_WAIT_EXT: if (EXT_ACK_I) st_ff <= S_IDLE; // see RL21
        S_MIR: st_ff <= S_WB;
        S_MMUL_RD: st_ff <= S_MMUL_ACC;
        S_MMUL_ACC:
        begin
          addr_ff <= addr_ff + 32'h0000_0004;
          k_ff <= k_ff + 2'h1;
          st_ff <= (k_ff == MTX_LAST) ? S_WB : S_MMUL_RD;
        end
        S_WB: st_ff <= S_IDLE;
      endcase
  end
  //////////////////////////////////////////////////////////////////////////////
  // Memory ports
  assign INT_RD_O = (st_ff == S_ISSUE && is_int) || (st_ff == S_MMUL_RD); // see RL15
  assign INT_ADDR_O = addr_ff;
  always_comb
  begin
    EXT_REQ_O.req = (st_ff == S_WAIT_EXT);
    EXT_REQ_O.addr = addr_ff;
    EXT_REQ_O.size = (cmd_ff.op == OP_BYTE) ? SZ_BYTE : (cmd_ff.op == OP_HALF) ? SZ_HALF :
                     (cmd_ff.op == OP_PHRASE) ? SZ_PHRASE : SZ_LONG;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Writeback data and register file
  always_comb
  begin
    wb_data = res_ff;
    if (st_ff == S_WB_INT)
      wb_data = INT_RDATA_I; // see RL15
    else if (st_ff == S_WAIT_EXT)
      unique case (cmd_ff.op)
        OP_BYTE: wb_data = {24'h000000, EXT_RDATA_I[{addr_ff[2:0], 3'h0} +: 8]}; // see RL13
        OP_HALF: wb_data = {16'h0000, EXT_RDATA_I[{addr_ff[2:1], 4'h0} +: 16]}; // see RL14
        OP_PHRASE: wb_data = EXT_RDATA_I[31:0]; // see RL16
        default: wb_data = EXT_RDATA_I[{addr_ff[2], 5'h00} +: 32];
      endcase
  end
  assign rf_we = (st_ff == S_WB_INT) || (st_ff == S_WAIT_EXT && EXT_ACK_I) || (st_ff == S_WB); // see RL21
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      for (int i = 0; i < 32; i++)
        rf_ff[i] <= 32'h0000_0000;
    end
    else if (rf_we)
      rf_ff[cmd_ff.rd] <= wb_data;
    else if (bus_wr && WB_ADR_I[RF_SEL_BIT])
      rf_ff[WB_ADR_I[6:2]] <= (WB_DAT_I & wmask) | (rf_ff[WB_ADR_I[6:2]] & ~wmask);
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      high_ff <= 32'h0000_0000;
    else if (st_ff == S_WB_INT)
      high_ff <= INT_RDATA_I; // see RL17
    else if (st_ff == S_WAIT_EXT && EXT_ACK_I)
      high_ff <= EXT_RDATA_I[63:32]; // see RL16 see RL17
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mirror and matrix datapath
  assign mtx_reg = cmd_ff.rs + {3'h0, k_ff};
  assign prod = 32'($signed(INT_RDATA_I[15:0])) * 32'($signed(rf_ff[mtx_reg][15:0]));
  assign acc_sum = {1'b0, acc_ff} + {1'b0, prod};
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      res_ff <= 32'h0000_0000;
      acc_ff <= 32'h0000_0000;
    end
    else if (st_ff == S_C1)
    begin
      res_ff <= rf_ff[cmd_ff.rd]; // see RL19
      acc_ff <= 32'h0000_0000;
    end
    else if (st_ff == S_MIR)
      res_ff <= mir_q; // see RL18
    else if (st_ff == S_MMUL_ACC)
    begin
      acc_ff <= acc_sum[31:0];
      res_ff <= acc_sum[31:0]; // see RL20
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flags and status; hardware set wins over software clear
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      flag_ff <= FLAG_RST;
    else if (st_ff == S_MIR)
    begin
      flag_ff[FL_Z] <= (mir_q == 32'h0000_0000); // see RL19
      flag_ff[FL_N] <= mir_q[31];
    end
    else if (st_ff == S_MMUL_ACC && k_ff == MTX_LAST)
      flag_ff <= {acc_sum[32], acc_sum[31], (acc_sum[31:0] == 32'h0000_0000)}; // see RL20
    else if (bus_wr && WB_ADR_I == ADR_FLAG && WB_SEL_I[0])
      flag_ff <= WB_DAT_I[2:0];
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      taken_ff <= 1'b0;
      align_ff <= 1'b0;
      illegal_ff <= 1'b0;
    end
    else
    begin
      if (st_ff == S_C1 && cmd_ff.op == OP_JUMP)
        taken_ff <= take; // see RL6
      if (st_ff == S_C1 && is_load && misalign && !illegal_op)
        align_ff <= 1'b1;
      else if (bus_wr && WB_ADR_I == ADR_STAT && WB_SEL_I[0] && WB_DAT_I[ST_ALIGN])
        align_ff <= 1'b0;
      if (st_ff == S_C1 && illegal_op)
        illegal_ff <= 1'b1;
      else if (bus_wr && WB_ADR_I == ADR_STAT && WB_SEL_I[0] && WB_DAT_I[ST_ILLEGAL])
        illegal_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  logic jump_c1, int_long, mir_c1;
  assign jump_c1 = (st_ff == S_C1) && (cmd_ff.op == OP_JUMP);
  assign int_long = (st_ff == S_C1) && (cmd_ff.op == OP_LONG) && !misalign && ((c1_addr & INT_MASK) == INT_BASE);
  assign mir_c1 = (st_ff == S_C1) && (cmd_ff.op == OP_MIRROR) && !illegal_op;
  property p_zclr; jump_c1 && cmd_ff.imm[CC_ZCLR] && flag_ff[FL_Z] |=> !taken_ff; endproperty
  a_zclr: assert property (p_zclr) else $error("jump taken with zero set"); // see RL1
  property p_zset; jump_c1 && cmd_ff.imm[CC_ZSET] && !flag_ff[FL_Z] |=> !taken_ff; endproperty
  a_zset: assert property (p_zset) else $error("jump taken with zero clear"); // see RL2
  property p_sclr; jump_c1 && cmd_ff.imm[CC_SCLR] && cmd_ff.imm[CC_SEL] && flag_ff[FL_N] |=> !taken_ff; endproperty
  a_sclr: assert property (p_sclr) else $error("jump taken with negative set"); // see RL3 see RL5
  property p_sset; jump_c1 && cmd_ff.imm[CC_SSET] && !cmd_ff.imm[CC_SEL] && !flag_ff[FL_C] |=> !taken_ff; endproperty
  a_sset: assert property (p_sset) else $error("jump taken with carry clear"); // see RL4 see RL5
  property p_always; jump_c1 && cmd_ff.imm[3:0] == 4'h0 |=> taken_ff; endproperty
  a_always: assert property (p_always) else $error("unconditional jump not taken"); // see RL6
  property p_jflags; jump_c1 |=> $stable(flag_ff) ##1 $stable(flag_ff); endproperty
  a_jflags: assert property (p_jflags) else $error("jump changed flags"); // see RL7
  property p_long_int; int_long |-> ##1 INT_RD_O ##1 (st_ff == S_WB_INT && rf_we); endproperty
  a_long_int: assert property (p_long_int) else $error("internal load not written in cycle 3"); // see RL9
  property p_idx;
    (st_ff == S_C1) && (cmd_ff.op == OP_IDX) && !misalign && !illegal_op |-> ##3 (st_ff == S_ISSUE);
  endproperty
  a_idx: assert property (p_idx) else $error("indexed load not issued in cycle 4"); // see RL11
  property p_stall; (st_ff == S_WAIT_EXT) && !EXT_ACK_I |-> !rf_we ##1 (st_ff == S_WAIT_EXT); endproperty
  a_stall: assert property (p_stall) else $error("external load left before answer"); // see RL21
  property p_byte;
    (st_ff == S_WAIT_EXT) && EXT_ACK_I && (cmd_ff.op == OP_BYTE) |-> wb_data[31:8] == 24'h000000;
  endproperty
  a_byte: assert property (p_byte) else $error("byte load not zero-extended"); // see RL13
  property p_high; (st_ff == S_WAIT_EXT) && EXT_ACK_I |=> high_ff == $past(EXT_RDATA_I[63:32]); endproperty
  a_high: assert property (p_high) else $error("high word not latched"); // see RL17
  property p_mir;
    mir_c1 |-> ##2 (rf_we && wb_data[31] == $past(rf_ff[cmd_ff.rd][0], 2) && flag_ff[FL_N] == wb_data[31]);
  endproperty
  a_mir: assert property (p_mir) else $error("mirror result wrong or late"); // see RL19
  c_taken: cover property (jump_c1 ##1 taken_ff);
  c_ext: cover property ((st_ff == S_WAIT_EXT) && EXT_ACK_I);
  c_mir: cover property (mir_c1 ##2 rf_we);
  c_mmul: cover property ((st_ff == S_MMUL_ACC) && k_ff == MTX_LAST);
endmodule // exec_unit

// [test/mem_partner.sv]
// Model of the local RAM and the external memory bus
module mem_partner
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] lat_i,
  input wire logic int_rd_i,
  input wire logic [31:0] int_addr_i,
  output logic [31:0] int_rdata_o,
  input wire exec_pkg::ext_req_t ext_req_i,
  output logic ext_ack_o,
  output logic [63:0] ext_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  logic [3:0] wait_ff;
  logic [31:0] ph_adr;
  function automatic logic [31:0] word_at(input logic [31:0] a);
    return {~a[15:0], a[15:0]};
  endfunction
  assign ph_adr = {ext_req_i.addr[31:3], 3'h0};
  ////////////////////////////////////////
  // Valid one cycle after the strobe, then scrambled
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      int_rdata_o <= 32'h0;
    else if (int_rd_i)
      int_rdata_o <= word_at({int_addr_i[31:2], 2'h0});
    else
      int_rdata_o <= ~int_rdata_o;
  end
  // Answers lat_i + 1 cycles into a request
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wait_ff <= 4'h0;
      ext_ack_o <= 1'b0;
      ext_rdata_o <= 64'h0;
    end
    else if (ext_req_i.req && !ext_ack_o && wait_ff == lat_i)
    begin
      wait_ff <= 4'h0;
      ext_ack_o <= 1'b1;
      ext_rdata_o <= {word_at(ph_adr + 32'h4), word_at(ph_adr)};
    end
    else
    begin
      wait_ff <= (ext_req_i.req && !ext_ack_o) ? wait_ff + 4'h1 : 4'h0;
      ext_ack_o <= 1'b0;
      ext_rdata_o <= ~ext_rdata_o;
    end
  end
endmodule // mem_partner

// [test/risc_jump_load_mirror_exec_tb.sv]
// Self-checking bench for the jump, load, mirror and matrix unit
module risc_jump_load_mirror_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  logic clk, rst_n, cyc, stb, we, ack, int_rd, ext_ack, busy, taken;
  logic [3:0] sel, lat;
  logic [7:0] adr;
  logic [31:0] dat_w, dat_r, int_addr, int_rdata;
  logic [63:0] ext_rdata;
  logic [1:0] ext_size;
  ext_req_t ext_req;
  int fail_count = 0;
  int comparisons = 0;
  exec_unit uut (.REF_CLK_I(clk), .ARST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_SEL_I(sel), .WB_ADR_I(adr), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack), .INT_RD_O(int_rd),
    .INT_ADDR_O(int_addr), .INT_RDATA_I(int_rdata), .EXT_REQ_O(ext_req), .EXT_ACK_I(ext_ack),
    .EXT_RDATA_I(ext_rdata), .BUSY_O(busy), .JUMP_TAKEN_O(taken));
  mem_partner mem (.clk_i(clk), .arst_n_i(rst_n), .lat_i(lat), .int_rd_i(int_rd), .int_addr_i(int_addr),
    .int_rdata_o(int_rdata), .ext_req_i(ext_req), .ext_ack_o(ext_ack), .ext_rdata_o(ext_rdata));
  // Last access size shown on the external bus
  always @(posedge clk)
    if (ext_req.req)
      ext_size <= ext_req.size;
  ////////////////////////////////////////
  function automatic logic [31:0] mw(input logic [31:0] a);
    return {~a[15:0], a[15:0]};
  endfunction
  function automatic logic [7:0] rf(input int n);
    return 8'h80 + 8'(n * 4);
  endfunction
  function automatic logic [31:0] mk(input logic [3:0] op, input logic bb, input logic [4:0] imm, rs, rd);
    return {12'h000, cmd_t'{op, bb, imm, rs, rd}};
  endfunction
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic give_up(input string what);
    fail_count++;
    $display("[ERR] %s expected handshake seen timeout", what);
    print_verdict();
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] s, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= a;
    dat_w <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 50)
      give_up("bus ack");
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, 4'hF, a, d, q);
  endtask
  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] m = 32'hFFFF_FFFF);
    logic [31:0] q;
    wb(1'b0, 4'hF, a, 32'h0, q);
    chk(name, e, q & m);
  endtask
  // Issue a command and count its busy cycles
  task automatic run(input logic [31:0] c, input int exp_n);
    int n;
    n = 0;
    wr(ADR_CMD, c);
    @(posedge clk);
    while (busy === 1'b1 && n < 200)
    begin
      n++;
      @(posedge clk);
    end
    if (n >= 200)
      give_up("busy end");
    if (exp_n > 0)
      chk("busy cycles", 32'(exp_n), 32'(n));
  endtask
  ////////////////////////////////////////
  task automatic test_regs();
    logic [31:0] q;
    rdchk("flags reset", ADR_FLAG, 32'h0, 32'h7);
    rdchk("matrix reset", ADR_MTX, MTX_RST);
    wb(1'b1, 4'hE, ADR_CFG, 32'h0, q);
    rdchk("cfg", ADR_CFG, 32'h3, 32'h3);
    wr(8'h40, 32'hFFFF_FFFF);
    rdchk("unmapped", 8'h40, 32'h0);
    $display("test_regs done");
  endtask
  task automatic test_jump();
    logic [4:0] ccs [9] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h14, 5'h18, 5'h03, 5'h1A, 5'h10};
    logic [4:0] cc;
    logic [2:0] f;
    logic s, t;
    for (int i = 0; i < 72; i++)
    begin
      cc = ccs[i % 9];
      f = 3'(i / 9);
      s = cc[CC_SEL] ? f[FL_N] : f[FL_C];
      t = (!cc[CC_ZCLR] || !f[FL_Z]) && (!cc[CC_ZSET] || f[FL_Z]);
      t = t && (!cc[CC_SCLR] || !s) && (!cc[CC_SSET] || s);
      wr(ADR_FLAG, {29'h0, f});
      run(mk(OP_JUMP, 1'b0, cc, 5'h0, 5'h0), 1);
      chk("jump", {31'h0, t}, {31'h0, taken});
      rdchk("jump flags", ADR_FLAG, {29'h0, f}, 32'h7);
    end
    $display("test_jump done");
  endtask
  task automatic test_int();
    wr(rf(1), 32'h0001_0010);
    run(mk(OP_LONG, 1'b0, 5'h0, 5'h1, 5'h2), 3);
    rdchk("long", rf(2), mw(32'h0001_0010));
    rdchk("long high", ADR_HIGH, mw(32'h0001_0010));
    wr(rf(1), 32'h0001_0012);
    run(mk(OP_LONG, 1'b0, 5'h0, 5'h1, 5'h2), 1);
    rdchk("long align", ADR_STAT, 32'h4, 32'h4);
    wr(ADR_STAT, 32'h4);
    wr(rf(14), 32'h0001_0000);
    run(mk(OP_IDX, 1'b0, 5'h0, 5'h0, 5'h3), 5);
    rdchk("index 32", rf(3), mw(32'h0001_0080));
    wr(rf(15), 32'h0001_0100);
    run(mk(OP_IDX, 1'b1, 5'h1, 5'h0, 5'h3), 5);
    rdchk("index 1", rf(3), mw(32'h0001_0104));
    wr(rf(4), 32'h8);
    run(mk(OP_ROFF, 1'b1, 5'h0, 5'h4, 5'h5), 5);
    rdchk("reg offset", rf(5), mw(32'h0001_0108));
    wr(rf(1), 32'h0001_0004);
    run(mk(OP_BYTE, 1'b0, 5'h0, 5'h1, 5'h6), 0);
    rdchk("int byte", rf(6), mw(32'h0001_0004));
    $display("test_int done");
  endtask
  task automatic test_ext();
    logic [63:0] ph;
    ph = {mw(32'h0020_0004), mw(32'h0020_0000)};
    lat <= 4'h5;
    wr(rf(1), 32'h0020_0003);
    run(mk(OP_BYTE, 1'b0, 5'h0, 5'h1, 5'h7), 0);
    rdchk("ext byte", rf(7), {24'h0, ph[31:24]});
    chk("byte size", 32'(SZ_BYTE), 32'(ext_size));
    rdchk("ext high", ADR_HIGH, ph[63:32]);
    wr(rf(1), 32'h0020_0006);
    run(mk(OP_HALF, 1'b0, 5'h0, 5'h1, 5'h7), 0);
    rdchk("ext half", rf(7), {16'h0, ph[63:48]});
    chk("half size", 32'(SZ_HALF), 32'(ext_size));
    wr(rf(1), 32'h0020_0005);
    run(mk(OP_HALF, 1'b0, 5'h0, 5'h1, 5'h7), 1);
    rdchk("half align", ADR_STAT, 32'h4, 32'h4);
    wr(ADR_STAT, 32'h4);
    lat <= 4'h0;
    wr(rf(1), 32'h0020_0008);
    run(mk(OP_PHRASE, 1'b0, 5'h0, 5'h1, 5'h7), 0);
    rdchk("phrase low", rf(7), mw(32'h0020_0008));
    rdchk("phrase high", ADR_HIGH, mw(32'h0020_000C));
    chk("phrase size", 32'(SZ_PHRASE), 32'(ext_size));
    wr(rf(1), 32'h0020_0004);
    run(mk(OP_LONG, 1'b0, 5'h0, 5'h1, 5'h7), 0);
    rdchk("ext long", rf(7), ph[63:32]);
    chk("long size", 32'(SZ_LONG), 32'(ext_size));
    wr(ADR_CFG, 32'h2);
    run(mk(OP_PHRASE, 1'b0, 5'h0, 5'h1, 5'h7), 0);
    rdchk("phrase gfx", ADR_STAT, 32'h8, 32'h8);
    wr(ADR_STAT, 32'h8);
    wr(ADR_CFG, 32'h3);
    $display("test_ext done");
  endtask
  task automatic test_mirror();
    logic [31:0] src [3] = '{32'h1234_5678, 32'h1, 32'h0};
    logic [31:0] res [3] = '{32'h1E6A_2C48, 32'h8000_0000, 32'h0};
    logic [31:0] flg [3] = '{32'h0, 32'h2, 32'h1};
    for (int i = 0; i < 3; i++)
    begin
      wr(rf(9), src[i]);
      run(mk(OP_MIRROR, 1'b0, 5'h0, 5'h0, 5'h9), 3);
      rdchk("mirror", rf(9), res[i]);
      rdchk("mirror flags", ADR_FLAG, flg[i], 32'h3);
    end
    wr(ADR_CFG, 32'h1);
    run(mk(OP_MIRROR, 1'b0, 5'h0, 5'h0, 5'h9), 0);
    rdchk("mirror dsp", ADR_STAT, 32'h8, 32'h8);
    wr(ADR_STAT, 32'h8);
    wr(ADR_CFG, 32'h3);
    run(mk(4'hF, 1'b0, 5'h0, 5'h0, 5'h9), 1);
    rdchk("bad op", ADR_STAT, 32'h8, 32'h8);
    wr(ADR_STAT, 32'h8);
    $display("test_mirror done");
  endtask
  task automatic test_matrix();
    wr(rf(20), 32'h1);
    wr(rf(21), 32'h2);
    wr(rf(22), 32'h3);
    wr(rf(23), 32'h0000_FFF0);
    run(mk(OP_MMUL, 1'b0, 5'h0, 5'h14, 5'h18), 0);
    rdchk("matrix", rf(24), 32'hFFFF_FF60);
    rdchk("matrix flags", ADR_FLAG, 32'h2, 32'h7);
    $display("test_matrix done");
  endtask
  ////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'hF;
    adr = 8'h00;
    dat_w = 32'h0;
    lat = 4'h3;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    test_regs();
    test_jump();
    test_int();
    test_ext();
    test_mirror();
    test_matrix();
    print_verdict();
  end
endmodule // risc_jump_load_mirror_exec_tb
